// >>> hdl/acc_map.svh
// Summary of operation
// - result register shows previous value while a new conversion samples
// - after sampling, result clears to zero and a marker one enters at top
// - each decided bit shifts marker right and fills the freed upper bit
// - after nine marker shifts the conversion ends and running flag clears
// - software clearing running flag stops conversion, partial result kept
// - pin select bits 7-6 choose none, C, C+A, or C+B+A analog pins
// - clock select bits 5-4 choose sysclk/16, /8, /4, or oscillator
// - channel select bits 3-2 choose pin A, B, C, or 0.6V reference
// - writing one to bit 1 starts; hardware clears it on completion
// - power enable bit 0; while zero, setting running flag is ignored
// - pin select forces analog mode regardless of power enable
// - every reset sets channel select to 11
// - enabled comparator one output takes over analog pin C
// - comparator result bit 7 is positive above negative; writes ignored
// - active-low bit 6 drives result onto pin; on comparator one overrides pin select
// - polarity bit 5: one passes output, zero inverts it
// - comparator one bit 4 zero uses its output as timer-zero clock
// - comparator one selects negative pin or 0.6V, positive or negative pin
// - comparator two selects negative pin or reference, positive chain; its negative select drives no output
// - comparator enable bit 3; polarity, drive and timer bits act only while on
// - active-low wake enable bit 0 enables wake on output change
// - wake flag sets on enabled, latched, asleep and changed; cleared
// - entering sleep clears run and power, clock and channel go to 11
// - clock select change takes effect at next conversion start
// - channel select change takes effect after current conversion
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH
`define ACC_ADDR_CTRL     4'h0
`define ACC_ADDR_RESULT   4'h4
`define ACC_ADDR_CMP1     4'h8
`define ACC_ADDR_CMP2     4'hc
`define ACC_ADDR_WAKE     4'h0
`define ACC_CTRL_RST      8'hfc
`define ACC_CMP_RST       7'h7f
`define ACC_SEL_DEFAULT   2'h3
`define ACC_SAMPLE_TADS   4'h2
`define ACC_MARKER        9'h100
`define ACC_DIV16         4'hf
`define ACC_DIV8          4'h7
`define ACC_DIV4          4'h3
`endif

// >>> hdl/acc_pkg.sv
package acc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} acc_state_e;
  // converter control fields
  typedef struct packed {
    logic [1:0] pin_sel;
    logic [1:0] clk_sel;
    logic [1:0] chan_sel;
    logic       running;
    logic       power;
  } acc_ctrl_s;
  // comparator control, result bit kept out since it is live
  typedef struct packed {
    logic drive_n;
    logic polarity;
    logic sel4;
    logic on;
    logic neg_sel;
    logic sel1;
    logic wake_dis;
  } acc_cmp_s;
  typedef struct packed {
    acc_state_e st;
    acc_ctrl_s  ctrl;
    logic [1:0] clk_act;
    logic [1:0] chan_act;
    logic [8:0] sar;
    logic [3:0] div;
    logic [3:0] samp;
    acc_cmp_s   c1;
    acc_cmp_s   c2;
    logic [1:0] latched;
    logic       latch_ok;
    logic       wake_flag;
    logic [2:0] sleep_sy;
    logic [2:0] osc_sy;
    logic [2:0] c1_sy;
    logic [2:0] c2_sy;
    logic [2:0] bit_sy;
    logic       osc_last;
    logic       dph_wr;
    logic       dph_rd;
    logic [3:0] dph_addr;
    logic [7:0] rdata;
  } acc_state_s;
endpackage

// >>> hdl/acc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "acc_map.svh"
module acc_top (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sleep_req,
  input  wire logic        osc_clk,
  input  wire logic        sar_bit,
  input  wire logic        cmp1_raw,
  input  wire logic        cmp2_raw,
  input  wire logic        timer_clock_source_sel,
  output logic      [2:0]  analog_pins,
  output logic      [1:0]  adc_channel,
  output logic             adc_power,
  output logic             cmp1_pin_out,
  output logic             cmp1_pin_oe_n,
  output logic             cmp2_pin_out,
  output logic             cmp2_pin_oe_n,
  output logic             timer_zero_clk_from_cmp,
  output logic      [1:0]  cmp1_in_sel,
  output logic      [1:0]  cmp2_in_sel,
  output logic             comparator_wake_flag
);
  acc_pkg::acc_state_s r_reg;
  acc_pkg::acc_state_s r_next;

  logic       c1_out;
  logic       c2_out;
  logic       addr_ok;
  logic       tick;
  logic       osc_rise;
  logic       sleep_now;
  logic [7:0] wd;
  logic       c1_changed;
  logic       c2_changed;
  logic       wake_hit;
  logic       cmp_rd_take;
  logic       start_req;

  // the converter has a single clock; every divided rate is a one-cycle
  // tick from a free-running counter, so the sequencer never runs on a
  // derived clock and no second clock domain appears in the block
  // the oscillator rate is recovered from rising edges of its synchronised
  // level; this is coarse, but it keeps the whole block on ref_clk
  // limitation: an oscillator faster than a quarter of ref_clk is missed

  // divider per clock select
  // conversion clock divider terminal count per selection
  function automatic logic [3:0] div_max(input logic [1:0] sel);
    unique case (sel)
      2'h0: div_max = `ACC_DIV16;
      2'h1: div_max = `ACC_DIV8;
      default: div_max = `ACC_DIV4;
    endcase
  endfunction

  // comparator output after polarity, forced low while off
  function automatic logic cmp_out(input logic raw,
                                   input acc_pkg::acc_cmp_s c);
    cmp_out = c.on & (c.polarity ? raw : ~raw);
  endfunction

  // either comparator control offset; decoded in the address phase only
  function automatic logic is_cmp_addr(input logic [3:0] a);
    is_cmp_addr = (a == `ACC_ADDR_CMP1) || (a == `ACC_ADDR_CMP2);
  endfunction

  // analog pin mask {C,B,A} for a pin select code
  function automatic logic [2:0] pin_mask(input logic [1:0] sel);
    unique case (sel)
      2'h0: pin_mask = 3'h0;
      2'h1: pin_mask = 3'h4;
      2'h2: pin_mask = 3'h5;
      default: pin_mask = 3'h7;
    endcase
  endfunction

  // a control write runs the converter only with power in the same byte
  function automatic logic start_bits(input logic [7:0] d);
    start_bits = d[1] & d[0];
  endfunction

  // read data byte for a register offset; comparator bit 7 is live
  function automatic logic [7:0] read_mux(input logic [3:0] a,
                                          input acc_pkg::acc_ctrl_s ctrl,
                                          input logic [7:0] result,
                                          input logic o1,
                                          input acc_pkg::acc_cmp_s c1,
                                          input logic o2,
                                          input acc_pkg::acc_cmp_s c2);
    unique case (a)
      `ACC_ADDR_CTRL:   read_mux = ctrl;
      `ACC_ADDR_RESULT: read_mux = result;
      `ACC_ADDR_CMP1:   read_mux = {o1, c1};
      `ACC_ADDR_CMP2:   read_mux = {o2, c2};
      default:          read_mux = 8'h00;
    endcase
  endfunction

  assign c1_out    = cmp_out(r_reg.c1_sy[2], r_reg.c1);
  assign c2_out    = cmp_out(r_reg.c2_sy[2], r_reg.c2);
  assign sleep_now = r_reg.sleep_sy[2] & r_reg.sleep_sy[1];
  assign osc_rise  = (r_reg.osc_sy[2] & r_reg.osc_sy[1]) & ~r_reg.osc_last;
  assign tick      = (r_reg.clk_act == 2'h3) ? osc_rise
                   : (r_reg.div == div_max(r_reg.clk_act));
  assign addr_ok   = (haddr[31:4] == 28'h000_0000) && (haddr[1:0] == 2'h0);
  assign wd        = hwdata[7:0];
  assign start_req = start_bits(wd);

  // a read of either comparator register latches both outputs; reads
  // are side-effect free otherwise, so only this path needs decoding
  assign cmp_rd_take = hsel && hready && htrans[1] && !hwrite && addr_ok
                     && is_cmp_addr(haddr[3:0]);

  // change since the last latching read, per comparator; a comparator
  // with wake disabled may toggle freely in sleep without waking anyone
  // active-low wake enable gates each comparator
  assign c1_changed = !r_reg.c1.wake_dis && (c1_out != r_reg.latched[0]);
  assign c2_changed = !r_reg.c2.wake_dis && (c2_out != r_reg.latched[1]);
  // all four conditions meet in one cycle
  assign wake_hit   = sleep_now && r_reg.latch_ok
                    && (c1_changed || c2_changed);

  // bus is zero wait state, always OKAY
  // read data is captured at the address phase and stands through the
  // data phase; writes land at the edge that ends the data phase, so a
  // read right after a write to the same offset sees the new value
  // only when one idle cycle separates them
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = {24'h00_0000, r_reg.rdata};

  // pin routing
  always_comb begin
    // pin select decode
    // the select acts whether or not the converter is powered, so a
    // powered-down converter still keeps its pins out of digital use
    analog_pins = pin_mask(r_reg.ctrl.pin_sel);
    // comparator one output takes pin C
    if (r_reg.c1.on && !r_reg.c1.drive_n) begin
      analog_pins[2] = 1'b0;
    end
  end

  // analog mode independent of power; channel routing
  assign adc_channel   = r_reg.chan_act;
  assign adc_power     = r_reg.ctrl.power;
  // active-low drive enable; only while on
  assign cmp1_pin_oe_n = ~(r_reg.c1.on & ~r_reg.c1.drive_n);
  assign cmp2_pin_oe_n = ~(r_reg.c2.on & ~r_reg.c2.drive_n);
  assign cmp1_pin_out  = c1_out;
  assign cmp2_pin_out  = c2_out;
  // timer clock from comparator when bit is zero
  assign timer_zero_clk_from_cmp = r_reg.c1.on ? ~r_reg.c1.sel4
                                 : 1'b0;
  // {pos, neg} selects for comparator one
  assign cmp1_in_sel = {r_reg.c1.sel1, r_reg.c1.neg_sel};
  // positive chain {primary ? 2 : secondary code}
  assign cmp2_in_sel = r_reg.c2.sel1 ? 2'h2 : {1'b0, r_reg.c2.sel4};
  assign comparator_wake_flag = r_reg.wake_flag;

  // next-state logic
  always_comb begin
    r_next = r_reg;
    // three-flop chains for every pin-side input; only the last two
    // stages are read so a metastable first stage never reaches logic
    r_next.sleep_sy = {r_reg.sleep_sy[1:0], sleep_req};
    r_next.osc_sy   = {r_reg.osc_sy[1:0], osc_clk};
    r_next.c1_sy    = {r_reg.c1_sy[1:0], cmp1_raw};
    r_next.c2_sy    = {r_reg.c2_sy[1:0], cmp2_raw};
    r_next.bit_sy   = {r_reg.bit_sy[1:0], sar_bit};
    r_next.osc_last = r_reg.osc_sy[2] & r_reg.osc_sy[1];
    r_next.div      = tick ? 4'h0 : 4'(r_reg.div + 4'h1);
    r_next.dph_wr   = 1'b0;
    r_next.dph_rd   = 1'b0;

    // address phase capture
    if (hsel && hready && htrans[1]) begin
      r_next.dph_wr   = hwrite & addr_ok;
      r_next.dph_rd   = ~hwrite & addr_ok;
      r_next.dph_addr = haddr[3:0];
      r_next.rdata    = 8'h00;
      if (!hwrite && addr_ok) begin
        r_next.rdata = read_mux(haddr[3:0], r_reg.ctrl, r_reg.sar[7:0],
                                c1_out, r_reg.c1, c2_out, r_reg.c2);
      end
    end

    if (cmp_rd_take) begin
      r_next.latched  = {c2_out, c1_out};
      r_next.latch_ok = 1'b1;
    end

    // conversion sequencer
    // idle: the divider runs free and nothing in the result moves
    // sample: the previous result stays readable for a fixed number of
    // conversion ticks while the input settles on the held channel
    // convert: the register is cleared and a marker one enters at the
    // top; each tick shifts it right and stuffs the decided bit above it
    // the conversion ends on the tick that pushes the marker out, which
    // is why the result is nine bits wide inside the block
    // an abort simply returns to idle, so the marker position stays
    // visible and tells software how many bits were decided
    unique case (r_reg.st)
      acc_pkg::ST_IDLE: begin
        r_next.samp = 4'h0;
      end
      acc_pkg::ST_SAMPLE: begin
        // result untouched while sampling; fixed periods
        if (tick) begin
          r_next.samp = 4'(r_reg.samp + 4'h1);
          if (r_reg.samp == `ACC_SAMPLE_TADS) begin
            // clear then marker enters at top
            r_next.sar = `ACC_MARKER;
            r_next.st  = acc_pkg::ST_CONVERT;
          end
        end
      end
      acc_pkg::ST_CONVERT: begin
        if (tick) begin
          // shift marker right, stuff decided bit at top
          r_next.sar = {r_reg.bit_sy[2], r_reg.sar[8:1]};
          if (r_reg.sar[0]) begin
            r_next.st           = acc_pkg::ST_IDLE;
            r_next.ctrl.running = 1'b0;
            r_next.chan_act     = r_reg.ctrl.chan_sel;
          end
        end
      end
    endcase

    // register writes, data phase
    if (r_reg.dph_wr) begin
      unique case (r_reg.dph_addr)
        `ACC_ADDR_CTRL: begin
          r_next.ctrl.pin_sel  = wd[7:6];
          r_next.ctrl.clk_sel  = wd[5:4];
          r_next.ctrl.chan_sel = wd[3:2];
          r_next.ctrl.power    = wd[0];
          r_next.ctrl.running  = start_req;
          if (start_req && r_reg.st == acc_pkg::ST_IDLE) begin
            r_next.st       = acc_pkg::ST_SAMPLE;
            r_next.clk_act  = wd[5:4];
            r_next.chan_act = wd[3:2];
            r_next.div      = 4'h0;
          end else if (start_req) begin
            r_next.chan_act = r_reg.chan_act;
          end
          if (!start_req) begin
            // abort keeps partial result and marker
            r_next.st       = acc_pkg::ST_IDLE;
            r_next.chan_act = wd[3:2];
          end
        end
        `ACC_ADDR_RESULT: begin
          // a write during a conversion is overtaken by the next shift
          r_next.sar = {1'b0, wd};
        end
        `ACC_ADDR_CMP1: begin
          // bit 7 is live, so a write never reaches it
          r_next.c1.drive_n  = wd[6];
          r_next.c1.polarity = wd[5];
          r_next.c1.sel4     = wd[4];
          r_next.c1.on       = wd[3];
          r_next.c1.neg_sel  = wd[2];
          r_next.c1.sel1     = wd[1];
          r_next.c1.wake_dis = wd[0];
        end
        `ACC_ADDR_CMP2: begin
          // same layout; bit 4 and bit 1 form the positive chain
          r_next.c2.drive_n  = wd[6];
          r_next.c2.polarity = wd[5];
          r_next.c2.sel4     = wd[4];
          r_next.c2.on       = wd[3];
          r_next.c2.neg_sel  = wd[2];
          r_next.c2.sel1     = wd[1];
          r_next.c2.wake_dis = wd[0];
        end
        default: r_next.wake_flag = r_reg.wake_flag & ~wd[0];
      endcase
    end

    // sleep stops conversion, selects to defaults
    // sleep wins over a write in the same cycle, so software cannot
    // restart the converter while the device is asleep
    // the pin select is left alone so pins stay analog through sleep
    if (sleep_now) begin
      r_next.st            = acc_pkg::ST_IDLE;
      r_next.ctrl.running  = 1'b0;
      r_next.ctrl.power    = 1'b0;
      r_next.ctrl.clk_sel  = `ACC_SEL_DEFAULT;
      r_next.ctrl.chan_sel = `ACC_SEL_DEFAULT;
      r_next.chan_act      = `ACC_SEL_DEFAULT;
    end

    // wake flag set wins over software clear
    // placed last so a clear in the same cycle never hides a wake event
    if (wake_hit) begin
      r_next.wake_flag = 1'b1;
    end
  end

  // state register; channel select to 11 on reset
  // every reset is the same here: the control byte returns with all
  // selects at 11 and the converter off, the comparator registers read
  // back with every control bit set, and the wake flag is cleared
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r_reg          <= '0;
      r_reg.st       <= acc_pkg::ST_IDLE;
      r_reg.ctrl     <= `ACC_CTRL_RST;
      r_reg.clk_act  <= `ACC_SEL_DEFAULT;
      r_reg.chan_act <= `ACC_SEL_DEFAULT;
      r_reg.c1       <= `ACC_CMP_RST;
      r_reg.c2       <= `ACC_CMP_RST;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule
`default_nettype wire

// >>> test/acc_props.sv
`timescale 1ns/10ps
`default_nettype none
module acc_props (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        sleep_req,
  input wire logic [2:0]  analog_pins,
  input wire logic [1:0]  adc_channel,
  input wire logic        adc_power,
  input wire logic        cmp1_pin_oe_n,
  input wire logic        timer_zero_clk_from_cmp,
  input wire logic        comparator_wake_flag
);
  logic take;
  logic wr_ctrl_reg;
  logic wr_cmp1_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // mark write data phases so hwdata can be tied to its target register
  assign take = hsel && hready && htrans[1] && hwrite;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ctrl_reg <= 1'b0;
      wr_cmp1_reg <= 1'b0;
    end else begin
      wr_ctrl_reg <= take && haddr[3:0] == 4'h0;
      wr_cmp1_reg <= take && haddr[3:0] == 4'h8;
    end
  end
  // sleep is synchronised, so allow a few cycles before judging it
  sequence s_asleep;
    sleep_req [*6];
  endsequence
  property p_okay; hreadyout && !hresp; endproperty
  property p_pwr_off; wr_ctrl_reg && !hwdata[0] |=> !adc_power; endproperty
  property p_pins;
    wr_ctrl_reg |=> analog_pins[1:0] == {&$past(hwdata[7:6]), $past(hwdata[7])};
  endproperty
  property p_chan_rst; $rose(rstn) |-> adc_channel == 2'h3; endproperty
  property p_oe;
    wr_cmp1_reg && hwdata[3] |=> cmp1_pin_oe_n == $past(hwdata[6]);
  endproperty
  property p_tmr;
    wr_cmp1_reg && hwdata[3] |=> timer_zero_clk_from_cmp == !$past(hwdata[4]);
  endproperty
  property p_sleep; s_asleep |-> !adc_power; endproperty
  property p_wake; $rose(comparator_wake_flag) |-> $past(sleep_req); endproperty
  a_okay: assert property (p_okay) else $error("bus answer not okay");
  a_pwr_off: assert property (p_pwr_off) else $error("power stays on");
  a_pins: assert property (p_pins) else $error("analog pins wrong");
  a_chan_rst: assert property (p_chan_rst) else $error("channel reset");
  a_oe: assert property (p_oe) else $error("pin drive wrong");
  a_tmr: assert property (p_tmr) else $error("timer clock wrong");
  a_sleep: assert property (p_sleep) else $error("power on asleep");
  a_wake: assert property (p_wake) else $error("wake while awake");
endmodule
bind acc_top acc_props acc_props_inst (.ref_clk(ref_clk), .rstn(rstn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .sleep_req(sleep_req), .analog_pins(analog_pins),
  .adc_channel(adc_channel), .adc_power(adc_power),
  .cmp1_pin_oe_n(cmp1_pin_oe_n),
  .timer_zero_clk_from_cmp(timer_zero_clk_from_cmp),
  .comparator_wake_flag(comparator_wake_flag));
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        sleep_req = 1'b0;
  logic        osc_clk = 1'b0;
  logic        sar_bit = 1'b1;
  logic        cmp1_raw = 1'b1;
  wire logic   hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [2:0]  analog_pins;
  logic [1:0]  adc_channel;
  logic        adc_power;
  logic        cmp1_pin_out;
  logic        cmp1_pin_oe_n;
  logic        timer_zero_clk_from_cmp;
  logic        comparator_wake_flag;
  logic [7:0]  q;
  logic [7:0]  k;
  logic [2:0]  pm [4] = '{3'h0, 3'h0, 3'h1, 3'h3};
  integer      bad_count = 0;
  integer      n_compared = 0;
  integer      cyc = 0;
  integer      np = 0;
  integer      n4 = 0;
  assign hready = hreadyout;
  always #50 ref_clk = ~ref_clk;
  always #170 osc_clk = ~osc_clk;
  acc_top acc_top_inst (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .sleep_req(sleep_req),
    .osc_clk(osc_clk), .sar_bit(sar_bit), .cmp1_raw(cmp1_raw),
    .cmp2_raw(1'b0), .timer_clock_source_sel(1'b0),
    .analog_pins(analog_pins), .adc_channel(adc_channel),
    .adc_power(adc_power), .cmp1_pin_out(cmp1_pin_out),
    .cmp1_pin_oe_n(cmp1_pin_oe_n), .cmp2_pin_out(), .cmp2_pin_oe_n(),
    .timer_zero_clk_from_cmp(timer_zero_clk_from_cmp), .cmp1_in_sel(),
    .cmp2_in_sel(), .comparator_wake_flag(comparator_wake_flag));
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared = n_compared + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("MISMATCH at %0t: saw %h wanted %h", $time, g, e);
    end
  endtask
  // one single transfer; nothing is released before hready is seen high
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {28'h000_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge ref_clk);
    while (!hreadyout) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    @(posedge ref_clk);
    while (!hreadyout) @(posedge ref_clk);
    q = hrdata[7:0];
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  // poll the running flag; np counts polls so clock rates can be compared
  task automatic wait_done;
    np = 0;
    do begin
      xfer(1'b0, 4'h0, 8'h00);
      np = np + 1;
    end while (q[1] && np < 200);
    chk({7'h00, q[1]}, 8'h00);
  endtask
  // hang guard, well above the longest conversion sequence
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      bad_count = bad_count + 1;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(4'h0, 8'hfc);
    rd(4'h8, 8'hff);
    wr(4'h8, 8'h28);
    rd(4'h8, 8'ha8);
    @(negedge ref_clk);
    chk({5'h00, cmp1_pin_oe_n, cmp1_pin_out, timer_zero_clk_from_cmp}, 8'h03);
    wr(4'h8, 8'h08);
    @(negedge ref_clk);
    chk({7'h00, cmp1_pin_out}, 8'h00);
    wr(4'h0, 8'hfe);
    rd(4'h0, 8'hfc);
    $display("comparator and power test done");
    // comparator one drives its pin here, so pin C never turns analog
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, {i[1:0], 2'h2, i[1:0], 2'h1});
      @(negedge ref_clk);
      k = {2'h0, pm[i], i[1:0], 1'b1};
      chk({2'h0, analog_pins, adc_channel, adc_power}, k);
    end
    $display("pin and channel test done");
    wr(4'h0, 8'he3);
    rd(4'h4, 8'h00);
    wr(4'h0, 8'he7);
    @(negedge ref_clk);
    chk({6'h00, adc_channel}, 8'h00);
    wait_done();
    n4 = np;
    rd(4'h4, 8'hff);
    chk({6'h00, adc_channel}, 8'h01);
    sar_bit <= 1'b0;
    wr(4'h0, 8'hc3);
    rd(4'h4, 8'hff);
    wait_done();
    rd(4'h4, 8'h00);
    chk({7'h00, np > 3 * n4}, 8'h01);
    $display("conversion test done");
    sar_bit <= 1'b1;
    wr(4'h0, 8'he3);
    repeat (30) @(posedge ref_clk);
    wr(4'h0, 8'he1);
    rd(4'h0, 8'he1);
    xfer(1'b0, 4'h4, 8'h00);
    k = q;
    repeat (40) @(posedge ref_clk);
    rd(4'h4, k);
    $display("abort test done");
    wr(4'h8, 8'h2e);
    rd(4'h8, 8'hae);
    sleep_req <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk({7'h00, comparator_wake_flag}, 8'h00);
    cmp1_raw <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk({7'h00, comparator_wake_flag}, 8'h01);
    rd(4'h0, 8'hfc);
    $display("sleep and wake test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
